// ### hw/dimb_pkg.sv
/*
 * Constants, field layouts and state codes shared by the DDR2
 * initialisation, mode register and burst ordering block.
 * Assumes a single system clock domain; pins arrive asynchronously.
 */
package dimb_pkg;

   // -----------------------------------------------------------
   // register map (byte addresses on the Avalon slave)
   // -----------------------------------------------------------
   localparam logic [4:0] REG_STATUS = 5'h00;
   localparam logic [4:0] REG_MR = 5'h04;
   localparam logic [4:0] REG_EMR = 5'h08;
   localparam logic [4:0] REG_EMR2 = 5'h0C;
   localparam logic [4:0] REG_EMR3 = 5'h10;
   localparam logic [4:0] REG_CTRL = 5'h14;

   // control register: bit 0 check enable, bit 1 error clear
   localparam int CTRL_CHK_BIT = 0;
   localparam int CTRL_CLR_BIT = 1;
   localparam logic CTRL_CHK_RST = 1'h1;

   // status register fields
   localparam int ST_READY_BIT = 0;
   localparam int ST_LOCK_BIT = 1;
   localparam int ST_CKE_BIT = 2;
   localparam int ST_ERR_BIT = 3;
   localparam int ST_STATE_LSB = 4;

   // -----------------------------------------------------------
   // mode register fields
   // -----------------------------------------------------------
   localparam int MR_W = 14;
   localparam int COL_W = 10;
   localparam int BT_BIT = 3;
   localparam int CL_LSB = 4;
   localparam int DLLRST_BIT = 8;
   localparam int A10_BIT = 10;
   localparam int WR_LSB = 9;
   localparam int PD_BIT = 12;
   localparam int OCD_LSB = 7;
   localparam logic [2:0] BL8_CODE = 3'h3;
   localparam logic [2:0] WR_BIAS = 3'h1;
   localparam logic [2:0] OCD_DEF = 3'h7;
   localparam logic [2:0] OCD_EXIT = 3'h0;
   localparam logic [MR_W-1:0] MR_RST = 14'h0000;
   // M13 and the self-clearing M8 never stay set
   localparam logic [MR_W-1:0] MR_KEEP = 14'h1EFF;
   localparam logic [MR_W-1:0] EMR_KEEP = 14'h1FFF;

   // bank address of each load mode target
   localparam logic [2:0] BA_MR = 3'h0;
   localparam logic [2:0] BA_EMR = 3'h1;
   localparam logic [2:0] BA_EMR2 = 3'h2;
   localparam logic [2:0] BA_EMR3 = 3'h3;

   // clock cycles of CK for DLL lock (200)
   localparam int DLL_CNT_W = 8;
   localparam logic [DLL_CNT_W-1:0] DLL_LOCK_CK = 8'hC8;

   // command code {RAS#, CAS#, WE#} with CS# low
   typedef enum logic [2:0] {
      CMD_LM = 3'h0,
      CMD_REF = 3'h1,
      CMD_PRE = 3'h2,
      CMD_ACT = 3'h3,
      CMD_WR = 3'h4,
      CMD_RD = 3'h5,
      CMD_NOP = 3'h7
   } dimb_cmd_e;

   // initialisation tracker, Gray coded along the sequence
   typedef enum logic [3:0] {
      S_PWRUP = 4'h0,
      S_CKE = 4'h1,
      S_PRE1 = 4'h3,
      S_EMR2 = 4'h2,
      S_EMR3 = 4'h6,
      S_DLLEN = 4'h7,
      S_DLLRST = 4'h5,
      S_PRE2 = 4'h4,
      S_REF1 = 4'hC,
      S_REF2 = 4'hD,
      S_MROP = 4'hF,
      S_OCDDEF = 4'hE,
      S_DONE = 4'hA
   } dimb_init_e;

endpackage

// ### hw/dimb_sync.sv
/*
 * Two flip-flop synchroniser for a vector of independent pin levels.
 * Assumes each bit is a level; the first stage feeds only the second.
 */
module dimb_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end

endmodule

// ### hw/dimb_burst.sv
/*
 * Column order within a burst block: low three column bits for beat idx.
 * Assumes idx stays below the burst length; bit 2 holds for length 4.
 */
module dimb_burst (
   // burst setup
   input wire logic [2:0] start,
   input wire logic bl8,
   input wire logic intlv,
   // beat
   input wire logic [2:0] idx,
   output logic [2:0] col
);

   logic [2:0] seq_w;
   logic [2:0] ilv_w;
   logic [2:0] pick_w;

   // count up modulo the block, or xor with the beat count
   assign seq_w = 3'(start + idx);
   assign ilv_w = start ^ idx;
   assign pick_w = intlv ? ilv_w : seq_w;
   assign col = bl8 ? pick_w : {start[2], pick_w[1:0]};

endmodule

// ### hw/dimb_top.sv
/*
 * DDR2 device side: command capture, mode registers, init tracking,
 * DLL lock timing and burst column ordering, with an Avalon-MM slave.
 * Assumes CK and the command pins are asynchronous to CLK_SYS and that
 * CK is much slower than CLK_SYS, so every CK edge is seen.
 */
// What this block does
// - device is ready 200 clocks after the DLL reset load
// - load mode with all bank bits zero writes the whole mode register
// - mode bits hold until reloaded; the DLL reset bit clears itself
// - burst length is 4 or 8, the most columns per access
// - burst length applies to reads and writes alike
// - upper column bits select the block, low bits the start
// - a burst wraps inside its block and never crosses it
// - M3 selects sequential (zero) or interleaved (one) order
// - sequential order counts up from start modulo the burst length
// - interleaved order is start xor beat count
// - M4 to M6 set the read CAS latency, 3 to 7 clocks
// - M9 to M11 set write recovery delaying the auto precharge
// - M12 selects slow-exit active power-down when one
module dimb_top
   import dimb_pkg::*;
(
   // system
   input wire logic CLK_SYS,
   input wire logic SRST,
   // avalon-mm slave
   input wire logic [4:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // ddr2 command pins
   input wire logic CK,
   input wire logic CKE,
   input wire logic CS_N,
   input wire logic RAS_N,
   input wire logic CAS_N,
   input wire logic WE_N,
   input wire logic [2:0] BA,
   input wire logic [13:0] A,
   // device state
   output logic DEV_READY,
   output logic OUT_EN,
   output logic PD_SLOW,
   // burst beats
   output logic BEAT_VALID,
   output logic BEAT_WR,
   output logic [9:0] BEAT_COL,
   output logic AP_PULSE
);

   // -----------------------------------------------------------
   // pin capture
   // -----------------------------------------------------------
   logic [22:0] pins_s;
   logic ck_s, cke_s, cs_n_s;
   logic [2:0] cmd_s;
   logic [2:0] ba_s;
   logic [13:0] a_s;
   logic ck_d_r, cke_d_r;

   dimb_sync #(.W(23)) u_sync (
      .clk(CLK_SYS),
      .srst(SRST),
      .d({CK, CKE, CS_N, RAS_N, CAS_N, WE_N, BA, A}),
      .q(pins_s)
   );

   assign ck_s = pins_s[22];
   assign cke_s = pins_s[21];
   assign cs_n_s = pins_s[20];
   assign cmd_s = pins_s[19:17];
   assign ba_s = pins_s[16:14];
   assign a_s = pins_s[13:0];

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         ck_d_r <= 1'b0;
         cke_d_r <= 1'b0;
      end else begin
         ck_d_r <= ck_s;
         cke_d_r <= cke_s;
      end
   end

   // -----------------------------------------------------------
   // command decode
   // -----------------------------------------------------------
   logic ck_rise, ck_edge, cmd_v, cmd_act;
   logic is_lm, is_ref, is_pre, is_rd, is_wr, pre_all;
   logic lm_mr, lm_emr, lm_emr2, lm_emr3;

   assign ck_rise = ck_s & ~ck_d_r;
   assign ck_edge = ck_s ^ ck_d_r;
   assign cmd_v = ck_rise & cke_s & ~cs_n_s;
   assign cmd_act = cmd_v & (cmd_s != CMD_NOP);
   assign is_lm = cmd_v & (cmd_s == CMD_LM);
   assign is_ref = cmd_v & (cmd_s == CMD_REF);
   assign is_pre = cmd_v & (cmd_s == CMD_PRE);
   assign is_rd = cmd_v & (cmd_s == CMD_RD);
   assign is_wr = cmd_v & (cmd_s == CMD_WR);
   assign pre_all = is_pre & a_s[A10_BIT];
   assign lm_mr = is_lm & (ba_s == BA_MR);
   assign lm_emr = is_lm & (ba_s == BA_EMR);
   assign lm_emr2 = is_lm & (ba_s == BA_EMR2);
   assign lm_emr3 = is_lm & (ba_s == BA_EMR3);

   // -----------------------------------------------------------
   // mode registers
   // -----------------------------------------------------------
   logic [MR_W-1:0] mr_r, emr_r, emr2_r, emr3_r;

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         mr_r <= MR_RST;
         emr_r <= MR_RST;
         emr2_r <= MR_RST;
         emr3_r <= MR_RST;
      end else begin
         if (lm_mr) begin
            mr_r <= a_s & MR_KEEP;
         end
         if (lm_emr) begin
            emr_r <= a_s & EMR_KEEP;
         end
         if (lm_emr2) begin
            emr2_r <= a_s & EMR_KEEP;
         end
         if (lm_emr3) begin
            emr3_r <= a_s & EMR_KEEP;
         end
      end
   end

   // -----------------------------------------------------------
   // initialisation tracker
   // -----------------------------------------------------------
   dimb_init_e st_r, st_nxt, tgt;
   logic step_ok, seq_bad, seq_err_r, chk_en_r, ctrl_clr;
   logic [2:0] ocd_w;

   assign ocd_w = a_s[OCD_LSB +: 3];

   always_comb begin
      step_ok = 1'b0;
      tgt = st_r;
      case (st_r)
         S_PWRUP: begin
            tgt = S_CKE;
            step_ok = cke_s;
         end
         S_CKE: begin
            tgt = S_PRE1;
            step_ok = pre_all;
         end
         S_PRE1: begin
            tgt = S_EMR2;
            step_ok = lm_emr2;
         end
         S_EMR2: begin
            tgt = S_EMR3;
            step_ok = lm_emr3;
         end
         S_EMR3: begin
            tgt = S_DLLEN;
            step_ok = lm_emr & ~a_s[0];
         end
         S_DLLEN: begin
            tgt = S_DLLRST;
            step_ok = lm_mr & a_s[DLLRST_BIT];
         end
         S_DLLRST: begin
            tgt = S_PRE2;
            step_ok = pre_all;
         end
         S_PRE2: begin
            tgt = S_REF1;
            step_ok = is_ref;
         end
         S_REF1: begin
            tgt = S_REF2;
            step_ok = is_ref;
         end
         S_REF2: begin
            tgt = is_ref ? S_REF2 : S_MROP;
            step_ok = is_ref | (lm_mr & ~a_s[DLLRST_BIT]);
         end
         S_MROP: begin
            tgt = S_OCDDEF;
            step_ok = lm_emr & (ocd_w == OCD_DEF);
         end
         S_OCDDEF: begin
            tgt = S_DONE;
            step_ok = lm_emr & (ocd_w == OCD_EXIT);
         end
         S_DONE: begin
            tgt = S_DONE;
            step_ok = 1'b1;
         end
         default: begin
            tgt = S_PWRUP;
            step_ok = 1'b1;
         end
      endcase
   end

   // advance on the expected command; other commands flag an error
   assign st_nxt = (step_ok & (cmd_act | st_r == S_PWRUP)) ? tgt : st_r;
   assign seq_bad = chk_en_r & (
      (cmd_act & ~step_ok) |
      (is_lm & ba_s[2]) |
      (~cke_s & cke_d_r & st_r != S_PWRUP & st_r != S_DONE));

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         st_r <= S_PWRUP;
         seq_err_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         seq_err_r <= seq_bad | (seq_err_r & ~ctrl_clr);
      end
   end

   // -----------------------------------------------------------
   // dll lock timing
   // -----------------------------------------------------------
   logic [DLL_CNT_W-1:0] dll_cnt_r;
   logic dll_run_r, dll_locked, ready_r;

   assign dll_locked = dll_run_r & (dll_cnt_r == DLL_LOCK_CK);

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         dll_cnt_r <= '0;
         dll_run_r <= 1'b0;
         ready_r <= 1'b0;
      end else begin
         if (lm_mr & a_s[DLLRST_BIT]) begin
            dll_cnt_r <= '0;
            dll_run_r <= 1'b1;
         end else if (ck_rise & dll_run_r & ~dll_locked) begin
            dll_cnt_r <= dll_cnt_r + 8'h01;
         end
         ready_r <= dll_locked & (st_r == S_DONE);
      end
   end

   // -----------------------------------------------------------
   // burst sequencer
   // -----------------------------------------------------------
   logic pend_r, busy_r, wr_r, ap_arm_r, bl8_r, intlv_r;
   logic [2:0] lat_r, idx_r, lat_w, cl_w, idx_use, col_lo;
   logic [COL_W-1:0] start_r, col_w;
   logic first_go, beat_go, beat_last;

   assign cl_w = mr_r[CL_LSB +: 3];
   assign lat_w = is_rd ? cl_w : 3'(cl_w - 3'h1);
   assign first_go = pend_r & ck_rise & (lat_r == 3'h1);
   assign beat_go = (first_go | (busy_r & ck_edge)) & cke_s;
   assign idx_use = first_go ? 3'h0 : idx_r;
   assign beat_last = beat_go & (idx_use == (bl8_r ? 3'h7 : 3'h3));

   dimb_burst u_burst (
      .start(start_r[2:0]),
      .bl8(bl8_r),
      .intlv(intlv_r),
      .idx(idx_use),
      .col(col_lo)
   );

   assign col_w = {start_r[COL_W-1:3], col_lo};

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         pend_r <= 1'b0;
         busy_r <= 1'b0;
         lat_r <= 3'h0;
         idx_r <= 3'h0;
         start_r <= '0;
         wr_r <= 1'b0;
         ap_arm_r <= 1'b0;
         bl8_r <= 1'b0;
         intlv_r <= 1'b0;
      end else if (is_rd | is_wr) begin
         pend_r <= 1'b1;
         busy_r <= 1'b0;
         lat_r <= lat_w;
         start_r <= a_s[COL_W-1:0];
         wr_r <= is_wr;
         ap_arm_r <= is_wr & a_s[A10_BIT];
         bl8_r <= mr_r[2:0] == BL8_CODE;
         intlv_r <= mr_r[BT_BIT];
      end else begin
         if (pend_r & ck_rise) begin
            lat_r <= 3'(lat_r - 3'h1);
         end
         if (first_go) begin
            pend_r <= 1'b0;
         end
         if (beat_go) begin
            idx_r <= 3'(idx_use + 3'h1);
            busy_r <= ~beat_last;
         end
      end
   end

   // write recovery before the internal auto precharge
   logic ap_run_r;
   logic [2:0] ap_cnt_r;

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         ap_run_r <= 1'b0;
         ap_cnt_r <= 3'h0;
         AP_PULSE <= 1'b0;
      end else begin
         AP_PULSE <= ap_run_r & ck_rise & (ap_cnt_r == 3'h1);
         if (beat_last & wr_r & ap_arm_r) begin
            ap_run_r <= 1'b1;
            ap_cnt_r <= 3'(mr_r[WR_LSB +: 3] + WR_BIAS);
         end else if (ap_run_r & ck_rise) begin
            ap_cnt_r <= 3'(ap_cnt_r - 3'h1);
            ap_run_r <= ap_cnt_r != 3'h1;
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         BEAT_VALID <= 1'b0;
         BEAT_WR <= 1'b0;
         BEAT_COL <= '0;
      end else begin
         BEAT_VALID <= beat_go;
         if (beat_go) begin
            BEAT_WR <= wr_r;
            BEAT_COL <= col_w;
         end
      end
   end

   assign DEV_READY = ready_r;
   assign OUT_EN = cke_s;
   assign PD_SLOW = mr_r[PD_BIT];

   // -----------------------------------------------------------
   // avalon-mm slave: one wait state on every access
   // -----------------------------------------------------------
   logic ack_r, req, wr_fire, ctrl_hit;
   logic [4:0] word_addr;
   logic [31:0] status_w, rd_mux;

   assign req = AVS_READ | AVS_WRITE;
   assign AVS_WAITREQUEST = req & ~ack_r;
   assign wr_fire = AVS_WRITE & ack_r;
   assign word_addr = {AVS_ADDRESS[4:2], 2'h0};
   assign ctrl_hit = wr_fire & (word_addr == REG_CTRL) & AVS_BYTEENABLE[0];
   assign ctrl_clr = ctrl_hit & AVS_WRITEDATA[CTRL_CLR_BIT];
   assign status_w = {24'h000000, st_r, seq_err_r, cke_s, dll_locked,
      ready_r};
   assign rd_mux =
      (word_addr == REG_STATUS) ? status_w :
      (word_addr == REG_MR) ? {18'h00000, mr_r} :
      (word_addr == REG_EMR) ? {18'h00000, emr_r} :
      (word_addr == REG_EMR2) ? {18'h00000, emr2_r} :
      (word_addr == REG_EMR3) ? {18'h00000, emr3_r} :
      (word_addr == REG_CTRL) ? {31'h00000000, chk_en_r} : 32'h00000000;

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         ack_r <= 1'b0;
         AVS_READDATA <= 32'h00000000;
         chk_en_r <= CTRL_CHK_RST;
      end else begin
         ack_r <= req & ~ack_r;
         if (AVS_READ & ~ack_r) begin
            AVS_READDATA <= rd_mux;
         end
         if (ctrl_hit) begin
            chk_en_r <= AVS_WRITEDATA[CTRL_CHK_BIT];
         end
      end
   end

   // -----------------------------------------------------------
   // assertions
   // -----------------------------------------------------------
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (SRST);

   a_m8_selfclr: assert property (!mr_r[DLLRST_BIT])
      else $error("dll reset bit stayed set");
   a_mr_load: assert property (lm_mr |=> mr_r == ($past(a_s) & MR_KEEP))
      else $error("mode register not loaded whole");
   a_ready_lock: assert property ($rose(ready_r) |->
      dll_cnt_r == DLL_LOCK_CK && st_r == S_DONE)
      else $error("ready before dll lock");
   a_out_dis: assert property (!cke_s |=> !BEAT_VALID)
      else $error("beat with cke low");
   a_beat_block: assert property (beat_go |->
      col_w[9:3] == start_r[9:3] && (bl8_r || col_w[2] == start_r[2]))
      else $error("burst left its block");
   a_seq_order: assert property (beat_go && !intlv_r |->
      col_lo[1:0] == 2'(start_r[1:0] + idx_use[1:0]))
      else $error("sequential order wrong");
   a_intlv_order: assert property (beat_go && intlv_r |->
      col_lo[1:0] == (start_r[1:0] ^ idx_use[1:0]))
      else $error("interleaved order wrong");
   a_beat_count: assert property (beat_last && !is_rd && !is_wr |=>
      !busy_r && !pend_r)
      else $error("burst ran past its length");

endmodule

// ### sim/dimb_ctrl_model.sv
/*
 * Behavioural DDR2 controller: free-running CK, CKE and command pins.
 * Assumes tasks are called from one bench process at a time.
 */
module dimb_ctrl_model
   import dimb_pkg::*;
(
   // ddr2 pins
   output logic ck,
   output logic cke,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [2:0] ba,
   output logic [13:0] a
);
   timeunit 1ns;
   timeprecision 1ns;

   int rises = 0;
   int cmd_rise = 0;
   int dll_rise = 0;

   initial begin
      ck = 1'b0;
      cke = 1'b0;
      {cs_n, ras_n, cas_n, we_n} = 4'hF;
      ba = 3'h0;
      a = 14'h0000;
      #13;
      forever #200 ck = ~ck;
   end

   always @(posedge ck) rises <= rises + 1;

   // one command set up on the falling edge, then a deselect cycle
   task automatic send(input dimb_cmd_e c, input logic [2:0] b,
                       input logic [13:0] ad);
      @(negedge ck);
      {cs_n, ras_n, cas_n, we_n} <= {1'b0, c};
      ba <= b;
      a <= ad;
      @(posedge ck);
      cmd_rise = rises + 1;
      @(negedge ck);
      cs_n <= 1'b1;
      ba <= ~b;
      a <= ~ad;
      @(posedge ck);
   endtask

   task automatic wait_ck(input int n);
      repeat (n) @(posedge ck);
   endtask

   task automatic init_seq(input logic e7, input logic [13:0] mr,
                           input logic [13:0] emr);
      cke <= 1'b0;
      wait_ck(500);
      @(negedge ck);
      cke <= 1'b1;
      wait_ck(2);
      send(CMD_PRE, 3'h0, 14'h0400);
      send(CMD_LM, BA_EMR2, {6'h00, e7, 7'h00});
      send(CMD_LM, BA_EMR3, 14'h0000);
      send(CMD_LM, BA_EMR, 14'h0000);
      send(CMD_LM, BA_MR, 14'h0100);
      dll_rise = cmd_rise;
      send(CMD_PRE, 3'h0, 14'h0400);
      send(CMD_REF, 3'h0, 14'h0000);
      send(CMD_REF, 3'h0, 14'h0000);
      send(CMD_LM, BA_MR, mr);
      send(CMD_LM, BA_EMR, emr | 14'h0380);
      send(CMD_LM, BA_EMR, emr);
   endtask
endmodule

// ### sim/ddr2_init_mode_burst_bench.sv
/*
 * Self-checking bench: Avalon register access, init sequence, bursts.
 * Assumes the controller model drives all DDR2 pins of the design.
 */
module ddr2_init_mode_burst_bench
   import dimb_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic [4:0] av_addr = 5'h00;
   logic av_rd = 1'b0;
   logic av_wr = 1'b0;
   logic [31:0] av_wdata = 32'h0;
   logic [31:0] av_rdata;
   logic av_wait;
   logic ck, cke, cs_n, ras_n, cas_n, we_n;
   logic [2:0] ba;
   logic [13:0] a;
   logic dev_ready, out_en, pd_slow, beat_valid, beat_wr, ap_pulse;
   logic [9:0] beat_col;
   int miscompares = 0;
   int check_count = 0;
   logic [9:0] cols[$];
   logic wrs[$];
   int beat_rise = 0;
   int ap_rise = 0;
   logic [31:0] rd;

   always #25 clk_sys = ~clk_sys;

   dimb_ctrl_model ctl (.ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .ba(ba), .a(a));

   dimb_top uut (.CLK_SYS(clk_sys), .SRST(srst), .AVS_ADDRESS(av_addr),
      .AVS_READ(av_rd), .AVS_WRITE(av_wr), .AVS_WRITEDATA(av_wdata),
      .AVS_BYTEENABLE(4'hF), .AVS_READDATA(av_rdata),
      .AVS_WAITREQUEST(av_wait), .CK(ck), .CKE(cke), .CS_N(cs_n),
      .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .BA(ba), .A(a),
      .DEV_READY(dev_ready), .OUT_EN(out_en), .PD_SLOW(pd_slow),
      .BEAT_VALID(beat_valid), .BEAT_WR(beat_wr), .BEAT_COL(beat_col),
      .AP_PULSE(ap_pulse));

   // -----------------------------------------------------------
   // monitor and tasks
   // -----------------------------------------------------------
   always @(negedge clk_sys) begin
      if (beat_valid === 1'b1) begin
         if (cols.size() == 0)
            beat_rise = ctl.rises;
         cols.push_back(beat_col);
         wrs.push_back(beat_wr);
      end
      if (ap_pulse === 1'b1)
         ap_rise = ctl.rises;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR at %0t: got %0h, expected %0h", $time, got, exp);
      end
   endtask

   task automatic av(input logic wr, input logic [4:0] ad,
                     input logic [31:0] wd, output logic [31:0] d);
      @(posedge clk_sys);
      av_rd <= ~wr;
      av_wr <= wr;
      av_addr <= ad;
      av_wdata <= wd;
      @(posedge clk_sys);
      // only the watchdog ends a wait that never gets an answer
      while (av_wait !== 1'b0)
         @(posedge clk_sys);
      d = av_rdata;
      av_rd <= 1'b0;
      av_wr <= 1'b0;
   endtask

   task automatic rchk(input logic [4:0] ad, input logic [31:0] exp);
      logic [31:0] d;
      av(1'b0, ad, 32'h0, d);
      chk(d, exp);
   endtask

   task automatic burst(input dimb_cmd_e c, input logic [13:0] ad,
                        input logic bl8, input logic il, input int lat);
      logic [2:0] s;
      logic [2:0] m;
      logic [2:0] o;
      m = bl8 ? 3'h7 : 3'h3;
      s = ad[2:0] & m;
      cols.delete();
      wrs.delete();
      ctl.send(c, 3'h0, ad);
      ctl.wait_ck(12);
      chk(cols.size(), bl8 ? 8 : 4);
      chk(beat_rise - ctl.cmd_rise, lat);
      for (int i = 0; i < cols.size(); i++) begin
         o = (il ? (s ^ i[2:0]) : (s + i[2:0])) & m;
         chk(cols[i], (ad[9:0] & ~{7'h00, m}) | {7'h00, o});
         chk(wrs[i], c == CMD_WR);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      #1_000_000;
      miscompares++;
      complete_run();
   end

   // -----------------------------------------------------------
   // test sequence
   // -----------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      rchk(REG_STATUS, 32'h0);
      rchk(REG_CTRL, 32'h1);
      rchk(5'h18, 32'h0);
      av(1'b1, REG_MR, 32'h0FFF, rd);
      rchk(REG_MR, 32'h0);
      @(negedge ck);
      ctl.cke <= 1'b1;
      ctl.wait_ck(4);
      rchk(REG_STATUS, 32'h14);
      ctl.send(CMD_LM, BA_EMR3, 14'h0000);
      ctl.wait_ck(1);
      rchk(REG_STATUS, 32'h1C);
      av(1'b1, REG_CTRL, 32'h3, rd);
      rchk(REG_STATUS, 32'h14);
      @(negedge ck);
      ctl.cke <= 1'b0;
      @(posedge clk_sys);
      srst <= 1'b1;
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      fork
         ctl.init_seq(1'b1, 14'h1433, 14'h0002);
         begin
            ctl.wait_ck(100);
            chk(out_en, 1'b0);
         end
      join
      wait (ctl.rises >= ctl.dll_rise + 195);
      chk(dev_ready, 1'b0);
      wait (ctl.rises >= ctl.dll_rise + 201);
      @(negedge clk_sys);
      chk(dev_ready, 1'b1);
      chk(out_en, 1'b1);
      chk(pd_slow, 1'b1);
      rchk(REG_STATUS, 32'hA7);
      rchk(REG_MR, 32'h1433);
      rchk(REG_EMR, 32'h0002);
      rchk(REG_EMR2, 32'h0080);
      rchk(REG_EMR3, 32'h0000);
      for (int k = 0; k < 8; k++) begin
         ctl.send(CMD_LM, BA_MR,
            14'h1430 | {10'h000, k[0], k[1] ? 3'h3 : 3'h2});
         burst(CMD_RD, {4'h0, 7'h05A, k[2] ? 3'h6 : 3'h5}, k[1], k[0],
            3);
      end
      ctl.send(CMD_LM, BA_MR, 14'h1433);
      burst(CMD_WR, 14'h0563, 1'b1, 1'b0, 2);
      chk(ap_rise - ctl.cmd_rise, 8);
      ctl.send(CMD_LM, BA_MR, 14'h1533);
      rchk(REG_MR, 32'h1433);
      ctl.send(CMD_LM, 3'h4, 14'h0000);
      rchk(REG_MR, 32'h1433);
      av(1'b0, REG_STATUS, 32'h0, rd);
      chk(rd[ST_ERR_BIT], 1'b1);
      // checking off: the same bad load must leave the cleared flag alone
      av(1'b1, REG_CTRL, 32'h2, rd);
      rchk(REG_CTRL, 32'h0);
      ctl.send(CMD_LM, 3'h4, 14'h0000);
      av(1'b0, REG_STATUS, 32'h0, rd);
      chk(rd[ST_ERR_BIT], 1'b0);
      complete_run();
   end
endmodule
